// ---- bbfc_defs.svh ----
// constants for the boot block flash host controller
`ifndef BBFC_DEFS_SVH
`define BBFC_DEFS_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define BBFC_OFS_CTRL 8'h00
`define BBFC_OFS_ADDR 8'h04
`define BBFC_OFS_WDATA 8'h08
`define BBFC_OFS_CMD 8'h0c
`define BBFC_OFS_STAT 8'h10
`define BBFC_OFS_RDATA 8'h14
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BBFC_CTRL_RUN 0
`define BBFC_CTRL_WP 1
`define BBFC_CTRL_WORD 2
`define BBFC_CTRL_SAFE 3
`define BBFC_CMD_WRITE 0
`define BBFC_CMD_WAITRDY 1
`define BBFC_ST_BUSY 0
`define BBFC_ST_RDY 1
`define BBFC_ST_RDOK 2
`define BBFC_ST_WROK 3
`define BBFC_ST_REFUSED 4
`define BBFC_ST_PEND 5
`define BBFC_ST_BOOT 6
`define BBFC_ST_BLK_LO 8
`define BBFC_ST_BLK_HI 13
// ----------------------------------------------------------------
// array layout, word addresses, top boot
// ----------------------------------------------------------------
`define BBFC_MAIN_END 20'hf8000
`define BBFC_MAIN_SHIFT 15
`define BBFC_SMALL_SHIFT 12
`define BBFC_MAIN_COUNT 6'h1f
`define BBFC_FIRST_BOOT 6'h25
// ----------------------------------------------------------------
// timing in ns and derived cycles at 100 MHz
// ----------------------------------------------------------------
`define BBFC_CLK_NS 10
`define BBFC_T_SETUP_NS 20
`define BBFC_T_WE_NS 50
`define BBFC_T_HOLD_NS 20
`define BBFC_T_ACC_NS 90
`define BBFC_T_RECOVER_NS 600
`define BBFC_T_WAKE_NS 1000
`define BBFC_CYC(ns) (((ns) + `BBFC_CLK_NS - 1) / `BBFC_CLK_NS)
`define BBFC_SYNC_CYC 2
`define BBFC_RD_ZERO 32'h0000_0000
`endif

// ---- bbfc_pkg.sv ----
// types shared by the boot block flash host controller
package bbfc_pkg;
  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] dq_out;
    logic [15:0] dq_oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
  } bbfc_pins_t;

  typedef enum logic [2:0] {
    BBFC_IDLE = 3'b000,
    BBFC_SETUP = 3'b001,
    BBFC_STROBE = 3'b010,
    BBFC_HOLD = 3'b011
  } bbfc_state_t;
endpackage

// ---- bbfc_cycle.sv ----
// single asynchronous bus cycle toward the flash pins
`timescale 1ns/10ps
`include "bbfc_defs.svh"
module bbfc_cycle (
  input wire logic sys_clk_i, // 100 MHz
  input wire logic rst_n_i, // async reset
  input wire logic start_i, // start one cycle
  input wire logic write_i, // 1 write, 0 read
  input wire logic word_i, // 16-bit width
  input wire logic [20:0] addr_i, // byte or word address
  input wire logic [15:0] data_i, // write data
  input wire logic [15:0] dq_i, // data pins in
  output bbfc_pkg::bbfc_pins_t pins_o, // pin drive
  output logic busy_o, // cycle under way
  output logic done_o, // one-cycle end pulse
  output logic [15:0] rdata_o // captured read data
);
  bbfc_pkg::bbfc_state_t state_ff;
  bbfc_pkg::bbfc_state_t nxt_state;
  logic [7:0] cnt_ff;
  logic wr_ff;
  logic [15:0] dq_s1_ff;
  logic [15:0] dq_s2_ff;
  logic [7:0] nxt_cnt;

  // ----------------------------------------------------------------
  // pin data synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dq_s1_ff <= 16'h0000;
      dq_s2_ff <= 16'h0000;
    end else begin
      dq_s1_ff <= dq_i;
      dq_s2_ff <= dq_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff - 8'h01;
    case (state_ff)
      bbfc_pkg::BBFC_IDLE: begin
        nxt_cnt = 8'(`BBFC_CYC(`BBFC_T_SETUP_NS));
        if (start_i) begin
          nxt_state = bbfc_pkg::BBFC_SETUP;
        end
      end
      bbfc_pkg::BBFC_SETUP: begin
        if (cnt_ff == 8'h01) begin
          nxt_state = bbfc_pkg::BBFC_STROBE;
          // sync delay added so the sampled data has settled
          nxt_cnt = wr_ff ? 8'(`BBFC_CYC(`BBFC_T_WE_NS))
                          : 8'(`BBFC_CYC(`BBFC_T_ACC_NS) + `BBFC_SYNC_CYC);
        end
      end
      bbfc_pkg::BBFC_STROBE: begin
        if (cnt_ff == 8'h01) begin
          nxt_state = bbfc_pkg::BBFC_HOLD;
          nxt_cnt = 8'(`BBFC_CYC(`BBFC_T_HOLD_NS));
        end
      end
      bbfc_pkg::BBFC_HOLD: begin
        if (cnt_ff == 8'h01) begin
          nxt_state = bbfc_pkg::BBFC_IDLE;
        end
      end
      default: begin
        nxt_state = bbfc_pkg::BBFC_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= bbfc_pkg::BBFC_IDLE;
      cnt_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // ----------------------------------------------------------------
  // pin drive, all from flops
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ff <= 1'b0;
      pins_o <= '{addr: 20'h00000, dq_out: 16'h0000, dq_oe: 16'h0000, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
    end else if (state_ff == bbfc_pkg::BBFC_IDLE && start_i) begin
      wr_ff <= write_i;
      pins_o.ce_n <= 1'b0;
      pins_o.addr <= word_i ? addr_i[19:0] : addr_i[20:1];
      // low address on top data pin
      pins_o.dq_out <= word_i ? data_i : {addr_i[0], 7'h00, data_i[7:0]};
      pins_o.dq_oe <= write_i ? (word_i ? 16'hffff : 16'h80ff) : (word_i ? 16'h0000 : 16'h8000);
    end else if (nxt_state == bbfc_pkg::BBFC_STROBE && state_ff == bbfc_pkg::BBFC_SETUP) begin
      pins_o.we_n <= ~wr_ff;
      pins_o.oe_n <= wr_ff;
    end else if (nxt_state == bbfc_pkg::BBFC_HOLD && state_ff == bbfc_pkg::BBFC_STROBE) begin
      pins_o.we_n <= 1'b1;
      pins_o.oe_n <= 1'b1;
    end else if (nxt_state == bbfc_pkg::BBFC_IDLE && state_ff == bbfc_pkg::BBFC_HOLD) begin
      pins_o.ce_n <= 1'b1;
      pins_o.dq_oe <= 16'h0000;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 16'h0000;
    end else if (state_ff == bbfc_pkg::BBFC_STROBE && cnt_ff == 8'h01 && !wr_ff) begin
      rdata_o <= word_i ? dq_s2_ff : {8'h00, dq_s2_ff[7:0]};
    end
  end

  assign busy_o = (state_ff != bbfc_pkg::BBFC_IDLE);
  assign done_o = (state_ff == bbfc_pkg::BBFC_HOLD) && (cnt_ff == 8'h01);
endmodule // bbfc_cycle

// ---- bbfc_host.sv ----
// host controller for a boot block flash, AXI4-Lite register front end
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "bbfc_defs.svh"
module bbfc_host (
  input wire logic sys_clk_i, // 100 MHz
  input wire logic rst_n_i, // async reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // response valid
  input wire logic s_axi_bready, // response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read valid
  input wire logic s_axi_rready, // read ready
  output logic [19:0] flash_addr_o, // address pins
  output logic [15:0] flash_dq_o, // data pins out
  output logic [15:0] flash_dq_oe_o, // data pin enables
  input wire logic [15:0] flash_dq_i, // data pins in
  output logic chip_select_n_o, // chip enable
  output logic read_enable_n_o, // output enable
  output logic write_strobe_n_o, // write strobe
  output logic reset_powerdown_input_n_o, // flash reset pin
  output logic write_protect_n_o, // protect pin
  output logic word_mode_n_o, // width select, low for bytes
  input wire logic ready_busy_output_i // pulled-up open-drain status
);
  logic [3:0] ctrl_ff;
  logic [20:0] addr_ff;
  logic [15:0] wdata_ff;
  logic [15:0] last_rd_ff;
  logic refused_ff;
  logic pend_ff;
  logic pend_wr_ff, pend_wait_ff;
  logic aw_ff;
  logic w_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wbus_ff;
  logic [3:0] wstrb_ff;
  logic [15:0] rec_cnt_ff;
  logic [15:0] wake_cnt_ff;
  logic rdy_s1_ff;
  logic rdy_s2_ff;
  logic run_d_ff;
  logic wr_go;
  logic cmd_hit;
  logic launch;
  logic cyc_busy;
  logic cyc_done;
  logic [15:0] cyc_rdata;
  logic [15:0] drive_data;
  logic rd_ok;
  logic wr_ok;
  logic [5:0] blk_idx;
  bbfc_pkg::bbfc_pins_t pins;

  // block index of a word address, top boot layout
  function automatic logic [5:0] blk_of(input logic [19:0] wa);
    logic [19:0] off;
    off = wa - `BBFC_MAIN_END;
    if (wa < `BBFC_MAIN_END) begin
      blk_of = 6'(wa >> `BBFC_MAIN_SHIFT);
    end else begin
      blk_of = `BBFC_MAIN_COUNT + 6'(off >> `BBFC_SMALL_SHIFT);
    end
  endfunction

  // ----------------------------------------------------------------
  // ready/busy synchroniser and reset timers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdy_s1_ff <= 1'b0;
      rdy_s2_ff <= 1'b0;
    end else begin
      rdy_s1_ff <= ready_busy_output_i;
      rdy_s2_ff <= rdy_s1_ff;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_d_ff <= 1'b0;
      rec_cnt_ff <= 16'h0000;
      wake_cnt_ff <= 16'h0000;
    end else begin
      run_d_ff <= ctrl_ff[`BBFC_CTRL_RUN];
      if (!ctrl_ff[`BBFC_CTRL_RUN]) begin
        rec_cnt_ff <= 16'h0000;
        wake_cnt_ff <= 16'h0000;
      end else if (!run_d_ff) begin
        rec_cnt_ff <= 16'(`BBFC_CYC(`BBFC_T_RECOVER_NS));
        wake_cnt_ff <= 16'(`BBFC_CYC(`BBFC_T_WAKE_NS));
      end else begin
        if (rec_cnt_ff != 16'h0000) rec_cnt_ff <= rec_cnt_ff - 16'h0001;
        if (wake_cnt_ff != 16'h0000) wake_cnt_ff <= wake_cnt_ff - 16'h0001;
      end
    end
  end

  assign rd_ok = ctrl_ff[`BBFC_CTRL_RUN] && run_d_ff && (rec_cnt_ff == 16'h0000);
  assign wr_ok = ctrl_ff[`BBFC_CTRL_RUN] && run_d_ff && (wake_cnt_ff == 16'h0000);

  // ----------------------------------------------------------------
  // AXI4-Lite write side
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_ff;
  assign s_axi_wready = !w_ff;
  assign s_axi_bresp = 2'b00;
  assign wr_go = aw_ff && w_ff && !s_axi_bvalid;
  assign cmd_hit = wr_go && (awaddr_ff == `BBFC_OFS_CMD);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wbus_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff <= 1'b1;
        wbus_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= 4'h0;
      addr_ff <= 21'h000000;
      wdata_ff <= 16'h0000;
    end else if (wr_go && wstrb_ff[0]) begin
      case (awaddr_ff)
        `BBFC_OFS_CTRL: ctrl_ff <= wbus_ff[3:0];
        `BBFC_OFS_ADDR: addr_ff <= {wstrb_ff[2] ? wbus_ff[20:16] : addr_ff[20:16], wbus_ff[15:0]};
        `BBFC_OFS_WDATA: wdata_ff <= {wstrb_ff[1] ? wbus_ff[15:8] : wdata_ff[15:8], wbus_ff[7:0]};
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // command launch
  // ----------------------------------------------------------------
  // wait for ready before launching when the command sets WAITRDY
  assign launch = pend_ff && !cyc_busy && (!pend_wait_ff || rdy_s2_ff);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_ff <= 1'b0;
      pend_wr_ff <= 1'b0;
      pend_wait_ff <= 1'b0;
      refused_ff <= 1'b0;
    end else begin
      if (cmd_hit && wstrb_ff[0]) begin
        // no command is accepted while reset is held
        if (pend_ff || cyc_busy || !(wbus_ff[`BBFC_CMD_WRITE] ? wr_ok : rd_ok)) begin
          refused_ff <= 1'b1;
        end else begin
          pend_ff <= 1'b1;
          pend_wr_ff <= wbus_ff[`BBFC_CMD_WRITE];
          pend_wait_ff <= wbus_ff[`BBFC_CMD_WAITRDY];
        end
      end else if (wr_go && awaddr_ff == `BBFC_OFS_STAT && wbus_ff[`BBFC_ST_REFUSED]) begin
        refused_ff <= 1'b0;
      end
      if (launch) pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_rd_ff <= 16'hffff;
    end else if (cyc_done && !pend_wr_ff) begin
      last_rd_ff <= cyc_rdata;
    end
  end

  // ones where old data is already zero
  assign drive_data = ctrl_ff[`BBFC_CTRL_SAFE] ? ~(last_rd_ff & ~wdata_ff) : wdata_ff;

  // commands as single bus cycles
  bbfc_cycle u_cycle (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .start_i(launch),
    .write_i(pend_wr_ff),
    .word_i(ctrl_ff[`BBFC_CTRL_WORD]),
    .addr_i(addr_ff),
    .data_i(drive_data),
    .dq_i(flash_dq_i),
    .pins_o(pins),
    .busy_o(cyc_busy),
    .done_o(cyc_done),
    .rdata_o(cyc_rdata)
  );

  assign flash_addr_o = pins.addr;
  assign flash_dq_o = pins.dq_out;
  assign flash_dq_oe_o = pins.dq_oe;
  assign chip_select_n_o = pins.ce_n;
  assign read_enable_n_o = pins.oe_n;
  assign write_strobe_n_o = pins.we_n;
  assign reset_powerdown_input_n_o = ctrl_ff[`BBFC_CTRL_RUN];
  assign write_protect_n_o = ctrl_ff[`BBFC_CTRL_WP];
  assign word_mode_n_o = ctrl_ff[`BBFC_CTRL_WORD];
  assign blk_idx = blk_of(ctrl_ff[`BBFC_CTRL_WORD] ? addr_ff[19:0] : addr_ff[20:1]);

  // ----------------------------------------------------------------
  // AXI4-Lite read side
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = 2'b00;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `BBFC_RD_ZERO;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= `BBFC_RD_ZERO;
      case (s_axi_araddr)
        `BBFC_OFS_CTRL: s_axi_rdata[3:0] <= ctrl_ff;
        `BBFC_OFS_ADDR: s_axi_rdata[20:0] <= addr_ff;
        `BBFC_OFS_WDATA: s_axi_rdata[15:0] <= wdata_ff;
        `BBFC_OFS_STAT: begin
          s_axi_rdata[`BBFC_ST_BUSY] <= cyc_busy | pend_ff;
          s_axi_rdata[`BBFC_ST_RDY] <= rdy_s2_ff;
          s_axi_rdata[`BBFC_ST_RDOK] <= rd_ok;
          s_axi_rdata[`BBFC_ST_WROK] <= wr_ok;
          s_axi_rdata[`BBFC_ST_REFUSED] <= refused_ff;
          s_axi_rdata[`BBFC_ST_PEND] <= pend_ff;
          s_axi_rdata[`BBFC_ST_BOOT] <= (blk_idx >= `BBFC_FIRST_BOOT);
          s_axi_rdata[`BBFC_ST_BLK_HI:`BBFC_ST_BLK_LO] <= blk_idx;
        end
        `BBFC_OFS_RDATA: s_axi_rdata[15:0] <= last_rd_ff;
        default: ;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // bbfc_host

// ---- bbfc_host_monitor.sv ----
// checker for the flash host controller pins and bus
`timescale 1ns/10ps
module bbfc_host_monitor (
  input wire logic sys_clk_i, // clock
  input wire logic rst_n_i, // reset
  input wire logic [19:0] flash_addr_o, // address
  input wire logic [15:0] flash_dq_o, // data out
  input wire logic [15:0] flash_dq_oe_o, // enables
  input wire logic chip_select_n_o, // select
  input wire logic read_enable_n_o, // output enable
  input wire logic write_strobe_n_o, // strobe
  input wire logic reset_powerdown_input_n_o, // flash reset
  input wire logic word_mode_n_o, // width
  input wire logic s_axi_bvalid, // bvalid
  input wire logic s_axi_bready, // bready
  input wire logic s_axi_rvalid, // rvalid
  input wire logic s_axi_rready // rready
);
  localparam int WAKE_CYC = 99;
  localparam int REC_CYC = 59;
  logic [7:0] up_cnt_ff;
  // ----
  // cycles since the flash left reset, saturating
  // ----
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      up_cnt_ff <= 8'h00;
    end else if (!reset_powerdown_input_n_o) begin
      up_cnt_ff <= 8'h00;
    end else if (up_cnt_ff != 8'hff) begin
      up_cnt_ff <= up_cnt_ff + 8'h01;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_quiet_after_reset: assert property ($rose(rst_n_i) |-> chip_select_n_o && write_strobe_n_o
    && !reset_powerdown_input_n_o) else $error("bus not idle after reset");
  a_write_wake: assert property (!write_strobe_n_o |-> up_cnt_ff >= WAKE_CYC)
    else $error("strobe before wake time");
  a_read_recover: assert property (!read_enable_n_o && !chip_select_n_o |-> up_cnt_ff >= REC_CYC)
    else $error("read before recovery time");
  a_strobe_width: assert property ($fell(write_strobe_n_o) |-> !write_strobe_n_o [*5] ##1 write_strobe_n_o)
    else $error("strobe width wrong");
  a_capture_stable: assert property ($rose(write_strobe_n_o) |-> $stable(flash_addr_o) && $stable(flash_dq_o)
    && !chip_select_n_o) else $error("address or data moved at strobe rise");
  a_setup_before: assert property ($fell(write_strobe_n_o) |-> $past(chip_select_n_o, 2) == 1'b0
    && flash_dq_oe_o[7:0] == 8'hff) else $error("no setup before strobe");
  a_no_fight: assert property (!read_enable_n_o |-> flash_dq_oe_o[14:0] == 15'h0000 && write_strobe_n_o)
    else $error("data driven during read");
  a_byte_addr_pin: assert property (!word_mode_n_o && !write_strobe_n_o |-> flash_dq_oe_o[15])
    else $error("top data pin not driven in byte mode");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped early");
endmodule // bbfc_host_monitor
bind bbfc_host bbfc_host_monitor u_mon (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .flash_addr_o(flash_addr_o),
  .flash_dq_o(flash_dq_o), .flash_dq_oe_o(flash_dq_oe_o), .chip_select_n_o(chip_select_n_o),
  .read_enable_n_o(read_enable_n_o), .write_strobe_n_o(write_strobe_n_o), .word_mode_n_o(word_mode_n_o),
  .reset_powerdown_input_n_o(reset_powerdown_input_n_o), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ---- bbfc_flash_model.sv ----
// behavioural boot block flash for the controller bench
`timescale 1ns/10ps
module bbfc_flash_model #(
  parameter int BUSY_NS = 400 // program time, shortened
) (
  input wire logic [19:0] addr_i, // address pins
  input wire logic [15:0] dq_i, // resolved data wire
  input wire logic ce_n_i, // select
  input wire logic oe_n_i, // output enable
  input wire logic we_n_i, // strobe
  input wire logic rp_n_i, // reset pin
  input wire logic wp_n_i, // protect pin
  input wire logic byte_n_i, // width
  output logic [15:0] dq_o, // read drive
  output logic rb_low_o // pulls ready/busy low
);
  logic [15:0] mem [int];
  logic [15:0] old, d, rd;
  logic [15:0] junk = 16'ha5c3;
  int zero_rewrites = 0;
  realtime busy_t;
  initial rb_low_o = 1'b0;
  // released lines toggle so a stale value never looks valid
  always #5 junk = ~junk;
  // erased array, boot blocks are the top two 4K-word blocks
  function automatic logic [15:0] peek(input int a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction
  // latched on strobe rise, gated by reset, busy and protect
  always @(posedge we_n_i) begin
    if (!ce_n_i && rp_n_i && !rb_low_o && !(addr_i >= 20'hfe000 && !wp_n_i)) begin
      old = peek(addr_i);
      // byte lane chosen by top data pin
      if (!byte_n_i) begin
        d = dq_i[15] ? {dq_i[7:0], 8'hff} : {8'hff, dq_i[7:0]};
      end else begin
        d = dq_i;
      end
      if ((~old & ~d) != 16'h0000) begin
        zero_rewrites++;
      end
      mem[addr_i] = old & d;
      rb_low_o = 1'b1;
      busy_t = $realtime + BUSY_NS;
    end
  end
  // busy times itself out, reset ends it
  always #5 if (rb_low_o && (!rp_n_i || $realtime >= busy_t)) rb_low_o = 1'b0;
  // data only when selected, enabled and out of reset
  always @* begin
    rd = peek(addr_i);
    if (!ce_n_i && !oe_n_i && rp_n_i) begin
      dq_o = !byte_n_i ? {junk[15:8], dq_i[15] ? rd[15:8] : rd[7:0]} : rd;
    end else begin
      dq_o = junk;
    end
  end
endmodule // bbfc_flash_model

// ---- testbench.sv ----
// self-checking bench for the flash host controller
`timescale 1ns/10ps
`include "bbfc_defs.svh"
module testbench;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  wire logic [1:0] bresp, rresp;
  logic [31:0] rd_v;
  logic first_rdy;
  wire logic awready, wready, bvalid, arready, rvalid;
  wire logic [31:0] rdata;
  wire logic [19:0] f_addr;
  wire logic [15:0] f_dq, f_oe, m_dq, dq_wire;
  wire logic ce_n, oe_n, we_n, rp_n, wp_n, byte_n, rb_low;
  int error_cnt = 0;
  int samples_checked = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  assign dq_wire = (f_oe & f_dq) | (~f_oe & m_dq);
  bbfc_host DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flash_addr_o(f_addr),
    .flash_dq_o(f_dq), .flash_dq_oe_o(f_oe), .flash_dq_i(dq_wire), .chip_select_n_o(ce_n),
    .read_enable_n_o(oe_n), .write_strobe_n_o(we_n), .reset_powerdown_input_n_o(rp_n),
    .write_protect_n_o(wp_n), .word_mode_n_o(byte_n), .ready_busy_output_i(!rb_low));
  bbfc_flash_model #(.BUSY_NS(400)) flash (.addr_i(f_addr), .dq_i(dq_wire), .ce_n_i(ce_n), .oe_n_i(oe_n),
    .we_n_i(we_n), .rp_n_i(rp_n), .wp_n_i(wp_n), .byte_n_i(byte_n), .dq_o(m_dq), .rb_low_o(rb_low));
  task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    check32("bresp", 32'h0, {30'h0, bresp});
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    check32("rresp", 32'h0, {30'h0, rresp});
    rready <= 1'b0;
  endtask
  // one flash cycle; a write also waits out the device's own busy time
  task automatic flash_op(input logic [31:0] cmd, input logic [31:0] a, input logic [31:0] d);
    int n;
    axi_wr(`BBFC_OFS_ADDR, a);
    axi_wr(`BBFC_OFS_WDATA, d);
    axi_wr(`BBFC_OFS_CMD, cmd);
    n = 0;
    do begin
      axi_rd(`BBFC_OFS_STAT, rd_v);
      n++;
    end while ((rd_v[`BBFC_ST_BUSY] | rd_v[`BBFC_ST_PEND]) !== 1'b0 && n < 100);
    first_rdy = rd_v[`BBFC_ST_RDY];
    // no new order until the device is ready
    while (rd_v[`BBFC_ST_RDY] !== 1'b1 && n < 200) begin
      axi_rd(`BBFC_OFS_STAT, rd_v);
      n++;
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    error_cnt++;
    $display("watchdog expired");
    final_report();
  end
  initial begin
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    check32("pins", {28'h0, ce_n, we_n, rp_n, |f_oe}, 32'h0000_000c);
    axi_rd(`BBFC_OFS_CTRL, rd_v);
    check32("ctrl reset", 32'h0000_0000, rd_v);
    axi_rd(8'h3c, rd_v);
    check32("unmapped", 32'h0000_0000, rd_v);
    wstrb <= 4'he;
    axi_wr(`BBFC_OFS_CTRL, 32'h0000_0001);
    wstrb <= 4'hf;
    check32("masked ctrl", {31'h0, rp_n}, 32'h0);
    $display("test reset done");
    axi_wr(`BBFC_OFS_CTRL, 32'h0000_0007);
    flash_op(32'h1, 32'h100, 32'h1234);
    check32("refused", {31'h0, rd_v[`BBFC_ST_REFUSED]}, 32'h1);
    check16("early write", 16'hffff, flash.peek(32'h100));
    axi_wr(`BBFC_OFS_STAT, 32'h0000_0010);
    axi_rd(`BBFC_OFS_STAT, rd_v);
    check32("refused cleared", {31'h0, rd_v[`BBFC_ST_REFUSED]}, 32'h0);
    $display("test wake done");
    repeat (110) @(posedge sys_clk_i);
    axi_wr(`BBFC_OFS_CTRL, 32'h0000_000f);
    flash_op(32'h0, 32'h100, 32'h0);
    axi_rd(`BBFC_OFS_RDATA, rd_v);
    check32("erased read", 32'h0000_ffff, rd_v);
    flash_op(32'h1, 32'h100, 32'h00bd);
    flash_op(32'h0, 32'h100, 32'h0);
    flash_op(32'h1, 32'h100, 32'h00bc);
    check16("safe program", 16'h00bc, flash.peek(32'h100));
    check32("zero rewrites", 32'h0, flash.zero_rewrites);
    flash_op(32'h0, 32'h100, 32'h0);
    axi_rd(`BBFC_OFS_RDATA, rd_v);
    check32("read back", 32'h0000_00bc, rd_v);
    $display("test program done");
    axi_wr(`BBFC_OFS_CTRL, 32'h0000_0005);
    flash_op(32'h1, 32'hff000, 32'h0);
    check32("boot index", {rd_v[13:8], rd_v[`BBFC_ST_BOOT]}, {6'h26, 1'b1});
    check16("boot guarded", 16'hffff, flash.peek(32'hff000));
    flash_op(32'h3, 32'h8000, 32'h1234);
    check32("busy seen", {31'h0, first_rdy}, 32'h0);
    check32("main index", {rd_v[13:8], rd_v[`BBFC_ST_BOOT]}, {6'h01, 1'b0});
    check16("main write", 16'h1234, flash.peek(32'h8000));
    $display("test protect done");
    axi_wr(`BBFC_OFS_CTRL, 32'h0000_0001);
    flash_op(32'h1, 32'h010201, 32'h5a);
    check16("byte write", 16'h5aff, flash.peek(32'h8100));
    flash_op(32'h0, 32'h010201, 32'h0);
    axi_rd(`BBFC_OFS_RDATA, rd_v);
    check32("byte read", 32'h0000_005a, rd_v);
    check32("standby", {31'h0, ce_n}, 32'h1);
    $display("test byte done");
    final_report();
  end
endmodule // testbench
